// ==== inc/ccsr_pkg.sv ====
// Purpose: constants and types for the converter configuration and status register bank
// Assumes: byte-wide register access at the printed addresses
// Notes: multi-byte registers span consecutive byte addresses, low byte first
package ccsr_pkg;
    // -------------------------------------------------------------
    // register byte addresses
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_EDGE_POS = 8'h2c; // 3 bytes: 0x2c..0x2e
    localparam logic [7:0] ADDR_FULLSCALE = 8'h30; // 2 bytes: 0x30..0x31
    localparam logic [7:0] ADDR_POWER_MODE = 8'h37;
    localparam logic [7:0] ADDR_TIMESTAMP = 8'h3b;
    localparam logic [7:0] ADDR_REFOUT = 8'h3c;
    // -------------------------------------------------------------
    // reset values and codes
    // -------------------------------------------------------------
    localparam logic [23:0] RST_EDGE_POS = 24'h000000;
    localparam logic [15:0] RST_FULLSCALE = 16'ha000;
    localparam logic [7:0] RST_POWER_MODE = 8'h4b;
    localparam logic [7:0] RST_TIMESTAMP = 8'h00;
    localparam logic [7:0] RST_REFOUT = 8'h01;
    localparam logic [7:0] CODE_LOW_POWER = 8'h46;
    localparam logic [7:0] CODE_HIGH_PERF = 8'h4b;
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int TS_RECV_EN_BIT = 0;
    localparam int TS_PECL_BIT = 1;
    localparam int REFOUT_EN_BIT = 0;

    // register access request from the control port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccsr_req_t;

    // analog control outputs
    typedef struct packed {
        logic [15:0] fullscale_adjust;
        logic low_power_mode;
        logic high_perf_mode;
        logic timestamp_receiver_enable;
        logic timestamp_pecl_mode;
        logic reference_output_enable;
    } ccsr_ctrl_t;
endpackage

// ==== rtl/ccsr_regs.sv ====
// Purpose: configuration and status register bank of a multi-channel converter
// Assumes: control port decoded into byte read/write strobes on clk
// Notes: read data returned one cycle after the read strobe
// Notes: analog controls follow a taken write two cycles later
// Notes: status and pll inputs come from other clocks and pass two flops
// Notes: reserved power codes are stored but drive neither mode line
// Functional notes
// - read-only 24-bit field reports captured strobe edge position
// - 16-bit full-scale code, all channels, resets to 0xa000
// - power code 0x46 low power, 0x4b high performance, others reserved
// - timestamp receiver enabled only while control bit 0 set
// - timestamp control bit 1 selects low-voltage pecl receive mode
// - reference output enabled while bit 0 set and pll enabled
`timescale 1ns/1ps
module ccsr_regs (
    input wire logic clk, // control port clock, 200 MHz
    input wire logic nrst, // async reset, active low
    input wire ccsr_pkg::ccsr_req_t req, // byte access request
    input wire logic [23:0] edge_pos_in, // captured edge position from detector
    input wire logic pll_enable, // pll enable from pll control
    output logic [7:0] rdata, // read data, one cycle after rd
    output logic rvalid, // read data valid pulse
    output ccsr_pkg::ccsr_ctrl_t ctrl // registered analog controls
);
    logic [23:0] edge_sync1_q;
    logic [23:0] edge_sync2_q;
    logic [15:0] fullscale_q;
    logic [7:0] power_mode_q;
    logic [7:0] timestamp_q;
    logic [7:0] refout_q;
    logic pll_sync1_q;
    logic pll_sync2_q;
    logic [7:0] rdata_d;
    logic wr_fs_lo;
    logic wr_fs_hi;
    logic wr_power;
    logic wr_stamp;
    logic wr_refout;
    logic [15:0] fs_out_q;
    logic low_power_q;
    logic high_perf_q;
    logic ts_recv_q;
    logic ts_pecl_q;
    logic refout_en_q;

    // -------------------------------------------------------------
    // write decode
    // -------------------------------------------------------------
    // one strobe per writable byte; the edge position bytes get none,
    // so a stray host write there can never disturb the status
    assign wr_fs_lo = req.wr && (req.addr == ccsr_pkg::ADDR_FULLSCALE);
    assign wr_fs_hi = req.wr && (req.addr == ccsr_pkg::ADDR_FULLSCALE + 8'h01);
    assign wr_power = req.wr && (req.addr == ccsr_pkg::ADDR_POWER_MODE);
    assign wr_stamp = req.wr && (req.addr == ccsr_pkg::ADDR_TIMESTAMP);
    assign wr_refout = req.wr && (req.addr == ccsr_pkg::ADDR_REFOUT);

    // -------------------------------------------------------------
    // status capture
    // -------------------------------------------------------------
    // detector sits on the sample clock, so two stages before use;
    // a multi-bit word may tear, software should read it when settled
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            edge_sync1_q <= ccsr_pkg::RST_EDGE_POS;
            edge_sync2_q <= ccsr_pkg::RST_EDGE_POS;
        end else begin
            edge_sync1_q <= edge_pos_in;
            edge_sync2_q <= edge_sync1_q;
        end
    end

    // pll enable comes from the pll control side, so it is synchronised too
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pll_sync1_q <= 1'h0;
            pll_sync2_q <= 1'h0;
        end else begin
            pll_sync1_q <= pll_enable;
            pll_sync2_q <= pll_sync1_q;
        end
    end

    // -------------------------------------------------------------
    // writable registers
    // -------------------------------------------------------------
    // edge position addresses have no write path at all
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fullscale_q <= ccsr_pkg::RST_FULLSCALE;
        end else if (wr_fs_lo) begin
            fullscale_q[7:0] <= req.wdata;
        end else if (wr_fs_hi) begin
            fullscale_q[15:8] <= req.wdata;
        end
    end

    // code stored verbatim; reserved codes read back but drive neither mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            power_mode_q <= ccsr_pkg::RST_POWER_MODE;
        end else if (wr_power) begin
            power_mode_q <= req.wdata;
        end
    end

    // reserved bits stored as written so a readback shows misuse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timestamp_q <= ccsr_pkg::RST_TIMESTAMP;
        end else if (wr_stamp) begin
            timestamp_q <= req.wdata;
        end
    end

    // defaults on so the reference clock runs without any host write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            refout_q <= ccsr_pkg::RST_REFOUT;
        end else if (wr_refout) begin
            refout_q <= req.wdata;
        end
    end

    // -------------------------------------------------------------
    // read path
    // -------------------------------------------------------------
    // unmapped addresses read as zero
    always_comb begin
        rdata_d = 8'h00;
        unique case (req.addr)
            ccsr_pkg::ADDR_EDGE_POS: rdata_d = edge_sync2_q[7:0];
            ccsr_pkg::ADDR_EDGE_POS + 8'h01: rdata_d = edge_sync2_q[15:8];
            ccsr_pkg::ADDR_EDGE_POS + 8'h02: rdata_d = edge_sync2_q[23:16];
            ccsr_pkg::ADDR_FULLSCALE: rdata_d = fullscale_q[7:0];
            ccsr_pkg::ADDR_FULLSCALE + 8'h01: rdata_d = fullscale_q[15:8];
            ccsr_pkg::ADDR_POWER_MODE: rdata_d = power_mode_q;
            ccsr_pkg::ADDR_TIMESTAMP: rdata_d = timestamp_q;
            ccsr_pkg::ADDR_REFOUT: rdata_d = refout_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // valid pulses once for every taken read strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rvalid <= 1'h0;
        end else begin
            rvalid <= req.rd;
        end
    end

    // read byte holds until the next read, so a slow host can still pick it up
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            rdata <= rdata_d;
        end
    end

    // -------------------------------------------------------------
    // control outputs
    // -------------------------------------------------------------
    // each control has its own flop so the analog side never sees decode glitches;
    // the price is one extra cycle after a write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fs_out_q <= ccsr_pkg::RST_FULLSCALE;
        end else begin
            fs_out_q <= fullscale_q;
        end
    end

    // reserved codes leave both mode lines low rather than guess a mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_power_q <= (ccsr_pkg::RST_POWER_MODE == ccsr_pkg::CODE_LOW_POWER);
        end else begin
            low_power_q <= (power_mode_q == ccsr_pkg::CODE_LOW_POWER);
        end
    end

    // high performance only for its exact code
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            high_perf_q <= (ccsr_pkg::RST_POWER_MODE == ccsr_pkg::CODE_HIGH_PERF);
        end else begin
            high_perf_q <= (power_mode_q == ccsr_pkg::CODE_HIGH_PERF);
        end
    end

    // receiver stays off unless software asks for it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ts_recv_q <= ccsr_pkg::RST_TIMESTAMP[ccsr_pkg::TS_RECV_EN_BIT];
        end else begin
            ts_recv_q <= timestamp_q[ccsr_pkg::TS_RECV_EN_BIT];
        end
    end

    // termination mode; only meaningful while the receiver is on
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ts_pecl_q <= ccsr_pkg::RST_TIMESTAMP[ccsr_pkg::TS_PECL_BIT];
        end else begin
            ts_pecl_q <= timestamp_q[ccsr_pkg::TS_PECL_BIT];
        end
    end

    // the enable bit alone never turns the output on, the pll must run too;
    // seen through the synchroniser and this flop, so it lags the pll by three cycles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            refout_en_q <= 1'h0;
        end else begin
            refout_en_q <= refout_q[ccsr_pkg::REFOUT_EN_BIT] & pll_sync2_q;
        end
    end

    // packed in the order the package struct declares its fields
    assign ctrl = {fs_out_q, low_power_q, high_perf_q, ts_recv_q, ts_pecl_q, refout_en_q};
endmodule

// ==== sim/ccsr_host.sv ====
// Purpose: host software model on the control port
// Assumes: requests change on the falling edge
// Notes: idle address and data invert so stale values never pass
`timescale 1ns/1ps
module ccsr_host (
    input wire logic clk, // clock
    input wire logic [7:0] rdata, // read byte
    input wire logic rvalid, // read valid
    output ccsr_pkg::ccsr_req_t req // request
);
    initial req = '0;
    // byte write; the spare edge lets ctrl settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) req <= '{1'h1, 1'h0, a, d};
        @(negedge clk) req <= '{1'h0, 1'h0, ~a, ~d};
        @(negedge clk);
    endtask
    // byte read; the answer is fixed at one cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk) req <= '{1'h0, 1'h1, a, 8'h00};
        @(negedge clk) req <= '{1'h0, 1'h0, ~a, 8'hff};
        d = rdata;
        v = rvalid;
    endtask
endmodule

// ==== sim/ccsr_regs_sva.sv ====
// Purpose: port assertions for the register bank
// Assumes: one clock, async active-low reset
// Notes: ctrl lags a taken write by two edges
`timescale 1ns/1ps
module ccsr_regs_sva (
    input wire logic clk, // clock
    input wire logic nrst, // reset, active low
    input wire ccsr_pkg::ccsr_req_t req, // request
    input wire logic [23:0] edge_pos_in, // edge position
    input wire logic pll_enable, // pll enabled
    input wire logic [7:0] rdata, // read byte
    input wire logic rvalid, // read valid
    input wire ccsr_pkg::ccsr_ctrl_t ctrl // controls
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_read_answer: assert property (rvalid == $past(req.rd))
        else $error("rvalid not one cycle after rd");
    chk_fs_write: assert property (req.wr && req.addr == 8'h30 |-> ##2
        ctrl.fullscale_adjust[7:0] == $past(req.wdata, 2)) else $error("fullscale low byte");
    chk_power_code: assert property (req.wr && req.addr == 8'h37 |-> ##2
        ctrl.low_power_mode == ($past(req.wdata, 2) == 8'h46) &&
        ctrl.high_perf_mode == ($past(req.wdata, 2) == 8'h4b)) else $error("power mode decode");
    chk_ts_bits: assert property (req.wr && req.addr == 8'h3b |-> ##2
        {ctrl.timestamp_pecl_mode, ctrl.timestamp_receiver_enable} == $past(req.wdata[1:0], 2))
        else $error("timestamp bits");
    chk_ref_gate: assert property (!pll_enable [*4] |-> !ctrl.reference_output_enable)
        else $error("ref output without pll");
    chk_ref_off: assert property (req.wr && req.addr == 8'h3c && !req.wdata[0] |-> ##2
        !ctrl.reference_output_enable) else $error("ref output not off");
    chk_edge_read: assert property ($stable(edge_pos_in) [*3] ##0 req.rd && req.addr == 8'h2c
        |=> rdata == $past(edge_pos_in[7:0])) else $error("edge position byte");
    chk_unmapped_read: assert property (req.rd && req.addr == 8'h40 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind ccsr_regs ccsr_regs_sva u_ccsr_regs_sva (.clk(clk), .nrst(nrst), .req(req),
    .edge_pos_in(edge_pos_in), .pll_enable(pll_enable), .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl));

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for the register bank
// Assumes: host model makes every access
// Notes: expected values come from the register table
`timescale 1ns/1ps
module tb_top;
    logic clk, nrst, pll_enable, rvalid, v;
    logic [23:0] edge_pos_in, pos;
    logic [7:0] rdata, d;
    logic [7:0] pc[3] = '{8'h46, 8'h4b, 8'h50};
    ccsr_pkg::ccsr_req_t req;
    ccsr_pkg::ccsr_ctrl_t ctrl;
    int n_mismatch = 0, checks = 0;
    ccsr_regs u_ccsr_regs (.clk(clk), .nrst(nrst), .req(req), .edge_pos_in(edge_pos_in),
        .pll_enable(pll_enable), .rdata(rdata), .rvalid(rvalid), .ctrl(ctrl));
    ccsr_host u_ccsr_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // read a byte and compare it with its valid pulse
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        u_ccsr_host.rd(a, d, v);
        check("rvalid", 24'(v), 24'h1);
        check("rdata", 24'(d), 24'(e));
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        nrst = 1'h0;
        pll_enable = 1'h0;
        edge_pos_in = 24'h000000;
        repeat (6) @(negedge clk);
        nrst = 1'h1;
        // reset values, unmapped place included
        rchk(8'h2c, 8'h00);
        rchk(8'h31, 8'ha0);
        rchk(8'h37, 8'h4b);
        rchk(8'h3b, 8'h00);
        rchk(8'h3c, 8'h01);
        rchk(8'h40, 8'h00);
        // full-scale at the recommended floor, then 0xff in the high byte
        u_ccsr_host.wr(8'h30, 8'h00);
        u_ccsr_host.wr(8'h31, 8'h20);
        check("fs", 24'(ctrl.fullscale_adjust), 24'h2000);
        u_ccsr_host.wr(8'h31, 8'hff);
        rchk(8'h31, 8'hff);
        foreach (pc[i]) begin
            u_ccsr_host.wr(8'h37, pc[i]);
            check("lp", 24'(ctrl.low_power_mode), 24'(pc[i] == 8'h46));
            check("hp", 24'(ctrl.high_perf_mode), 24'(pc[i] == 8'h4b));
        end
        // reserved timestamp bits always written as zero
        for (int i = 0; i < 4; i++) begin
            u_ccsr_host.wr(8'h3b, 8'(i));
            check("ts_en", 24'(ctrl.timestamp_receiver_enable), 24'(i % 2));
            check("ts_pecl", 24'(ctrl.timestamp_pecl_mode), 24'(i / 2));
        end
        check("refo", 24'(ctrl.reference_output_enable), 24'h0);
        pll_enable = 1'h1;
        repeat (4) @(negedge clk);
        check("refo", 24'(ctrl.reference_output_enable), 24'h1);
        u_ccsr_host.wr(8'h3c, 8'h00);
        check("refo", 24'(ctrl.reference_output_enable), 24'h0);
        // status bytes follow the detector; writes there do nothing
        edge_pos_in = 24'h5a3c96;
        u_ccsr_host.wr(8'h2d, 8'hff);
        rchk(8'h2c, 8'h96);
        rchk(8'h2d, 8'h3c);
        rchk(8'h2e, 8'h5a);
        // software rebuilds the whole position word from its three bytes, low byte first
        for (int i = 0; i < 3; i++) begin
            u_ccsr_host.rd(8'h2c + 8'(i), d, v);
            pos[8*i +: 8] = d;
        end
        check("pos", pos, 24'h5a3c96);
        // a second reset mid-run puts every control back at once
        nrst = 1'h0;
        @(negedge clk);
        check("fs_rst", 24'(ctrl.fullscale_adjust), 24'h00a000);
        check("hp_rst", 24'(ctrl.high_perf_mode), 24'h000001);
        check("ts_rst", 24'(ctrl.timestamp_receiver_enable), 24'h000000);
        check("refo_rst", 24'(ctrl.reference_output_enable), 24'h000000);
        nrst = 1'h1;
        rchk(8'h31, 8'ha0);
        final_report();
    end
endmodule
